// ### dv/rbsp_host_model.sv
/*
  Host processor model on the control register port of the supervisor.
  Assumes requests are taken on a rising clk edge, one strobe cycle each.
*/
`timescale 1ns/1ps
module rbsp_host_model (
  // Clock and boot status
  input  wire logic        clk,
  input  wire logic        bootDone,
  // Register port
  output logic             regWrite,
  output logic             regRead,
  output logic [15:0]      regAddr,
  output logic [15:0]      regWdata,
  input  wire logic [15:0] regRdata
);
  // ----------------------------------------------------------------
  // Fixed initialisation writes, in order
  // ----------------------------------------------------------------
  logic [15:0] initAddr [16] = '{16'h0211, 16'h026E, 16'h026F, 16'h0270,
    16'h0410, 16'h0418, 16'h0420,
    16'h0441, 16'h0442, 16'h0443, 16'h047E, 16'h04B8,
    16'h04E4, 16'h04E5, 16'h04E6, 16'h04EB};
  logic [15:0] initData [16] = '{16'h0014, 16'h0064, 16'h00EA, 16'h1F16,
    16'h2080, 16'h2080, 16'h2080,
    16'hC759, 16'h2A08, 16'h5CFA, 16'h080E, 16'h1120,
    16'h0E0D, 16'h0E0D, 16'h0E0D, 16'h060E};

  // Idle port at time zero
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 16'hA5A5;
    regWdata = 16'h5A5A;
  end

  // Bounded wait until boot has finished
  task automatic wait_boot();
    for (int i = 0; i < 200 && bootDone !== 1'b1; i++) @(posedge clk);
    #1;
  endtask

  // One write; held off until boot completes or 200 clock cycles have passed
  task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
    wait_boot();
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask

  // One read; data is taken once the registered answer has settled
  task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask

  // Whole initialisation sequence
  task automatic run_init();
    for (int i = 0; i < 16; i++) write_reg(initAddr[i], initData[i]);
  endtask
endmodule

// ### dv/rbsp_supervisor_test.sv
/*
  Self-checking bench for the reset, boot and speaker protection supervisor.
  Assumes the host model in dv/ and shortened boot and shutdown counts.
*/
`timescale 1ns/1ps
module rbsp_supervisor_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        analogOk = 1'b1;
  logic        ioOk = 1'b1;
  logic        coreOk = 1'b0;
  logic        hwResetN = 1'b1;
  logic        warnIn = 1'b0;
  logic        threshIn = 1'b0;
  logic [1:0]  shortDet = 2'b00;
  logic        regWrite, regRead;
  logic [15:0] regAddr, regWdata, regRdata;
  logic [1:0]  spkOn;
  logic        warnEv, overEv, shortEv, shutEv;
  logic        coreRst, sleepAct, bootFlag, irqN, pinOut;
  int          failures = 0;
  int          total_checks = 0;
  int          cycleCnt = 0;
  int          warnCnt = 0, overCnt = 0, shortCnt = 0, shutCnt = 0;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  rbsp_supervisor #(.NUM_SPK(2), .BOOT_CYCLES(4), .SHUTDOWN_CYCLES(4)) i_dut (
    .clk(clk), .reset(reset), .analogSupplyOk(analogOk), .firstIoSupplyOk(ioOk),
    .coreSupplyOk(coreOk), .hwResetN(hwResetN), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .overtempWarnIn(warnIn),
    .overtempThreshIn(threshIn), .shortDetect(shortDet), .spkDriverOn(spkOn),
    .speakerOvertempWarnEvent(warnEv), .speaker_overtemp_event(overEv),
    .speakerShortEvent(shortEv), .speaker_shutdown_event(shutEv),
    .coreResetActive(coreRst), .sleepActive(sleepAct), .boot_complete_flag(bootFlag),
    .irqN(irqN), .fifthGeneralPinOut(pinOut));

  rbsp_host_model i_host (
    .clk(clk), .bootDone(bootFlag), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  // Event pulse counters and hang guard
  always @(posedge clk) begin
    warnCnt  += (warnEv === 1'b1);
    overCnt  += (overEv === 1'b1);
    shortCnt += (shortEv === 1'b1);
    shutCnt  += (shutEv === 1'b1);
    cycleCnt++;
    if (cycleCnt == 5000) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host.read_reg(a, d);
    check(d, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_host.write_reg(a, d);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    tick(4);
    // Core supply never seen yet: held in power-on reset, not in sleep
    check({13'h0, sleepAct, coreRst, bootFlag}, 16'h0002);
    // Core supply raised as the regulator enable pin would at power-up
    @(posedge clk) coreOk <= 1'b1;
    i_host.wait_boot();
    check({14'h0, bootFlag, irqN}, 16'h0002);
    rd(rbsp_pkg::STATUS5_ADDR, 16'h0100);
    i_host.run_init();
    // Warning level is its own event and leaves the drivers running
    wr(rbsp_pkg::PIN_SEL_ADDR, 16'(rbsp_pkg::PIN_WARN));
    wr(rbsp_pkg::SPK_CTRL_ADDR, 16'h0003);
    @(posedge clk) warnIn <= 1'b1;
    tick(3);
    check({13'h0, pinOut, spkOn}, 16'h0007);
    check(16'(warnCnt * 16 + overCnt), 16'h0010);
    // Threshold trip shuts every driver down, then reports completion
    @(posedge clk) threshIn <= 1'b1;
    tick(2);
    check({14'h0, spkOn}, 16'h0000);
    tick(8);
    check(16'(overCnt * 16 + shutCnt), 16'h0011);
    @(posedge clk) threshIn <= 1'b0;
    warnIn <= 1'b0;
    // Enable into a short fails on that driver only
    wr(rbsp_pkg::SPK_CTRL_ADDR, 16'h0000);
    @(posedge clk) shortDet <= 2'b01;
    wr(rbsp_pkg::PIN_SEL_ADDR, 16'(rbsp_pkg::PIN_SHORT));
    wr(rbsp_pkg::SPK_CTRL_ADDR, 16'h0003);
    tick(3);
    rd(rbsp_pkg::SPK_STAT_ADDR, 16'h0201);
    check({14'h0, pinOut, 1'b0}, 16'h0002);
    tick(8);
    check(16'(shortCnt * 16 + shutCnt), 16'h0012);
    @(posedge clk) shortDet <= 2'b00;
    wr(rbsp_pkg::SPK_CTRL_ADDR, 16'h0000);
    tick(2);
    rd(rbsp_pkg::SPK_STAT_ADDR, 16'h0000);
    wr(rbsp_pkg::SPK_CTRL_ADDR, 16'h0003);
    tick(3);
    rd(rbsp_pkg::SPK_STAT_ADDR, 16'h0300);
    // Software reset reruns boot and clears the pin selection
    wr(rbsp_pkg::PIN_SEL_ADDR, 16'(rbsp_pkg::PIN_BOOT));
    wr(rbsp_pkg::SWRESET_ADDR, 16'h1234);
    tick(1);
    check({13'h0, bootFlag, spkOn}, 16'h0000);
    i_host.wait_boot();
    rd(rbsp_pkg::PIN_SEL_ADDR, 16'h0000);
    // Sleep keeps the always-on pin selection through wake-up
    wr(rbsp_pkg::PIN_SEL_ADDR, 16'(rbsp_pkg::PIN_BOOT));
    tick(2);
    check({15'h0, pinOut}, 16'h0001);
    @(posedge clk) coreOk <= 1'b0;
    tick(3);
    check({13'h0, sleepAct, coreRst, bootFlag}, 16'h0006);
    @(posedge clk) coreOk <= 1'b1;
    i_host.wait_boot();
    rd(rbsp_pkg::PIN_SEL_ADDR, 16'h0004);
    // Dropout of either monitored supply is a fresh power-on reset
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      analogOk <= (i != 0);
      ioOk     <= (i == 0);
      tick(3);
      check({13'h0, sleepAct, coreRst, bootFlag}, 16'h0002);
      @(posedge clk) analogOk <= 1'b1;
      ioOk <= 1'b1;
      i_host.wait_boot();
      rd(rbsp_pkg::PIN_SEL_ADDR, 16'h0000);
      wr(rbsp_pkg::PIN_SEL_ADDR, 16'(rbsp_pkg::PIN_BOOT));
    end
    // Hardware reset pin restarts boot
    @(posedge clk) hwResetN <= 1'b0;
    tick(2);
    check({14'h0, bootFlag, irqN}, 16'h0001);
    @(posedge clk) hwResetN <= 1'b1;
    i_host.wait_boot();
    check({14'h0, bootFlag, irqN}, 16'h0002);
    final_report();
  end
endmodule

// ### rtl/rbsp_supervisor.sv
/*
  Reset, boot and class-D speaker protection supervisor.
  Assumes supply monitor levels, the reset pin and protection detector
  levels all arrive synchronous to clk.
*/
`timescale 1ns/1ps
module rbsp_supervisor #(
  parameter int NUM_SPK         = 2,
  parameter int BOOT_CYCLES     = rbsp_pkg::BOOT_CYCLES,
  parameter int SHUTDOWN_CYCLES = rbsp_pkg::SHUTDOWN_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Supply monitors and reset pin
  input  wire logic               analogSupplyOk,
  input  wire logic               firstIoSupplyOk,
  input  wire logic               coreSupplyOk,
  input  wire logic               hwResetN,
  // Control register port
  input  wire logic               regWrite,
  input  wire logic               regRead,
  input  wire logic [15:0]        regAddr,
  input  wire logic [15:0]        regWdata,
  output logic      [15:0]        regRdata,
  // Protection detectors
  input  wire logic               overtempWarnIn,
  input  wire logic               overtempThreshIn,
  input  wire logic [NUM_SPK-1:0] shortDetect,
  // Speaker drivers and events
  output logic      [NUM_SPK-1:0] spkDriverOn,
  output logic                    speakerOvertempWarnEvent,
  output logic                    speaker_overtemp_event,
  output logic                    speakerShortEvent,
  output logic                    speaker_shutdown_event,
  // Supervisor status
  output logic                    coreResetActive,
  output logic                    sleepActive,
  output logic                    boot_complete_flag,
  output logic                    irqN,
  output logic                    fifthGeneralPinOut
);

  localparam int SD_WAIT_MAX = SHUTDOWN_CYCLES + 2;

  rbsp_pkg::rbsp_state_t stateReg;
  rbsp_pkg::rbsp_state_t stateNext;
  logic [15:0]        bootCntReg;
  logic [15:0]        sdCntReg;
  logic               sdBusyReg;
  logic [NUM_SPK-1:0] spkCtrlReg;
  logic [NUM_SPK-1:0] enPrevReg;
  logic [NUM_SPK-1:0] shortFlagReg;
  logic [NUM_SPK-1:0] newShort;
  logic [NUM_SPK-1:0] threshTrip;
  logic [2:0]         pinSelReg;
  logic               warnPrevReg;
  logic               threshPrevReg;
  logic               supplyLost;
  logic               swReset;
  logic               restart;
  logic               coreRst;
  logic               anyTrip;

  // ----------------------------------------------------------------
  // Power and boot sequencing
  // ----------------------------------------------------------------

  // Reset sources
  assign supplyLost = !analogSupplyOk || !firstIoSupplyOk;
  assign swReset    = regWrite && (regAddr == rbsp_pkg::SWRESET_ADDR);
  assign restart    = !hwResetN || swReset;

  // Next supervisor state
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      rbsp_pkg::ST_OFF: begin
        if (!supplyLost && coreSupplyOk) stateNext = rbsp_pkg::ST_BOOT;
      end
      rbsp_pkg::ST_SLEEP: begin
        if (supplyLost) stateNext = rbsp_pkg::ST_OFF;
        else if (coreSupplyOk) stateNext = rbsp_pkg::ST_BOOT;
      end
      rbsp_pkg::ST_BOOT, rbsp_pkg::ST_READY: begin
        if (supplyLost) stateNext = rbsp_pkg::ST_OFF;
        else if (!coreSupplyOk) stateNext = rbsp_pkg::ST_SLEEP;
        else if (restart) stateNext = rbsp_pkg::ST_BOOT;
        else if (stateReg == rbsp_pkg::ST_BOOT && bootCntReg == 16'(BOOT_CYCLES - 1))
          stateNext = rbsp_pkg::ST_READY;
      end
    endcase
  end

  // State and boot counter
  always_ff @(posedge clk) begin
    if (reset) begin
      stateReg   <= rbsp_pkg::ST_OFF;
      bootCntReg <= 16'h0000;
    end else begin
      stateReg <= stateNext;
      if (stateReg == rbsp_pkg::ST_BOOT && stateNext == rbsp_pkg::ST_BOOT && !restart)
        bootCntReg <= bootCntReg + 16'h0001;
      else
        bootCntReg <= 16'h0000;
    end
  end

  // Boot flag and interrupt line, both follow entry to ready
  always_ff @(posedge clk) begin
    if (reset) begin
      boot_complete_flag <= 1'b0;
      irqN               <= 1'b1;
      coreResetActive    <= 1'b1;
      sleepActive        <= 1'b0;
    end else begin
      boot_complete_flag <= (stateNext == rbsp_pkg::ST_READY);
      irqN               <= (stateNext != rbsp_pkg::ST_READY);
      coreResetActive    <= (stateNext == rbsp_pkg::ST_OFF) || (stateNext == rbsp_pkg::ST_SLEEP);
      sleepActive        <= (stateNext == rbsp_pkg::ST_SLEEP);
    end
  end

  // Core logic reset: power loss, sleep, hardware or software reset
  assign coreRst = reset || stateReg == rbsp_pkg::ST_OFF || stateReg == rbsp_pkg::ST_SLEEP
                   || restart;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Speaker enables, cleared by every core reset
  always_ff @(posedge clk) begin
    if (coreRst) begin
      spkCtrlReg <= '0;
    end else if (regWrite && regAddr == rbsp_pkg::SPK_CTRL_ADDR) begin
      spkCtrlReg <= regWdata[NUM_SPK-1:0];
    end
  end

  // Always-on pin function, kept through sleep and wake
  always_ff @(posedge clk) begin
    if (reset || stateReg == rbsp_pkg::ST_OFF || restart) begin
      pinSelReg <= rbsp_pkg::PIN_SEL_RESET;
    end else if (regWrite && regAddr == rbsp_pkg::PIN_SEL_ADDR) begin
      pinSelReg <= regWdata[2:0];
    end
  end

  // Read data, unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      regRdata <= 16'h0000;
      unique case (regAddr)
        rbsp_pkg::STATUS5_ADDR:  regRdata[rbsp_pkg::BOOT_FLAG_BIT] <= boot_complete_flag;
        rbsp_pkg::SPK_CTRL_ADDR: regRdata[NUM_SPK-1:0] <= spkCtrlReg;
        rbsp_pkg::SPK_STAT_ADDR: begin
          regRdata[NUM_SPK-1:0] <= shortFlagReg;
          regRdata[rbsp_pkg::STAT_ON_LSB +: NUM_SPK] <= spkDriverOn;
        end
        rbsp_pkg::PIN_SEL_ADDR:  regRdata[2:0] <= pinSelReg;
        default:                 regRdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Speaker protection
  // ----------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SPK; gi++) begin : gSpk
      logic enRise;
      assign enRise        = spkCtrlReg[gi] && !enPrevReg[gi];
      assign newShort[gi]  = spkCtrlReg[gi] && shortDetect[gi] && !shortFlagReg[gi]
                             && (enRise || spkDriverOn[gi]);
      assign threshTrip[gi] = spkDriverOn[gi] && spkCtrlReg[gi] && overtempThreshIn;

      // Driver state: on only from a clean enable edge
      always_ff @(posedge clk) begin
        if (coreRst || !spkCtrlReg[gi]) begin
          spkDriverOn[gi]  <= 1'b0;
          shortFlagReg[gi] <= 1'b0;
          enPrevReg[gi]    <= 1'b0;
        end else begin
          enPrevReg[gi] <= 1'b1;
          if (newShort[gi]) shortFlagReg[gi] <= 1'b1;
          if (enRise)
            spkDriverOn[gi] <= !shortDetect[gi] && !overtempThreshIn;
          else if (shortDetect[gi] || overtempThreshIn)
            spkDriverOn[gi] <= 1'b0;
        end
      end

      // Enable into a short never turns the driver on
      short_enable_fail_a: assert property (@(posedge clk) disable iff (reset)
        enRise && shortDetect[gi] |=> !spkDriverOn[gi])
        else $error("driver turned on into a short");
      // Status clears while disabled
      short_flag_clear_a: assert property (@(posedge clk) disable iff (reset)
        !spkCtrlReg[gi] |=> !shortFlagReg[gi])
        else $error("short status held with driver disabled");
    end
  endgenerate

  assign anyTrip = (|newShort) || (|threshTrip);

  // Temperature edges and short event pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      warnPrevReg              <= 1'b0;
      threshPrevReg            <= 1'b0;
      speakerOvertempWarnEvent <= 1'b0;
      speaker_overtemp_event   <= 1'b0;
      speakerShortEvent        <= 1'b0;
    end else begin
      warnPrevReg              <= overtempWarnIn;
      threshPrevReg            <= overtempThreshIn;
      speakerOvertempWarnEvent <= overtempWarnIn && !warnPrevReg;
      speaker_overtemp_event   <= overtempThreshIn && !threshPrevReg;
      speakerShortEvent        <= |newShort;
    end
  end

  // Shutdown completion timer, a new trip restarts it
  always_ff @(posedge clk) begin
    if (coreRst) begin
      sdBusyReg              <= 1'b0;
      sdCntReg               <= 16'h0000;
      speaker_shutdown_event <= 1'b0;
    end else begin
      speaker_shutdown_event <= 1'b0;
      if (anyTrip) begin
        sdBusyReg <= 1'b1;
        sdCntReg  <= 16'h0000;
      end else if (sdBusyReg && sdCntReg == 16'(SHUTDOWN_CYCLES - 1)) begin
        sdBusyReg              <= 1'b0;
        speaker_shutdown_event <= 1'b1;
      end else if (sdBusyReg) begin
        sdCntReg <= sdCntReg + 16'h0001;
      end
    end
  end

  // Protection or boot flag on the fifth general pin
  always_ff @(posedge clk) begin
    if (reset) begin
      fifthGeneralPinOut <= 1'b0;
    end else begin
      unique case (pinSelReg)
        rbsp_pkg::PIN_WARN:   fifthGeneralPinOut <= overtempWarnIn;
        rbsp_pkg::PIN_THRESH: fifthGeneralPinOut <= overtempThreshIn;
        rbsp_pkg::PIN_SHORT:  fifthGeneralPinOut <= |shortFlagReg;
        rbsp_pkg::PIN_BOOT:   fifthGeneralPinOut <= boot_complete_flag;
        default:              fifthGeneralPinOut <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence bootDone_s;
    $rose(boot_complete_flag) ##0 $fell(irqN);
  endsequence

  supply_hold_a: assert property (!analogSupplyOk || !firstIoSupplyOk || !coreSupplyOk
    |=> coreResetActive && !boot_complete_flag)
    else $error("core left reset with a supply low");
  dropout_por_a: assert property (!analogSupplyOk |=> stateReg == rbsp_pkg::ST_OFF)
    else $error("supply dropout did not restart power-on");
  sleep_entry_a: assert property (analogSupplyOk && firstIoSupplyOk && !coreSupplyOk
    && stateReg != rbsp_pkg::ST_OFF |=> sleepActive)
    else $error("sleep not entered with core supply low");
  boot_irq_a: assert property ($rose(boot_complete_flag) |-> bootDone_s)
    else $error("boot completion without interrupt falling edge");
  boot_length_a: assert property ($rose(boot_complete_flag)
    |-> $past(stateReg) == rbsp_pkg::ST_BOOT && $past(bootCntReg) == 16'(BOOT_CYCLES - 1))
    else $error("boot flag set before boot finished");
  restart_flag_a: assert property (restart |=> !boot_complete_flag)
    else $error("boot flag high during restart");
  swreset_clear_a: assert property (swReset |=> spkCtrlReg == '0)
    else $error("software reset left control state");
  thresh_off_a: assert property (overtempThreshIn |=> spkDriverOn == '0)
    else $error("driver on above temperature threshold");
  shutdown_event_a: assert property (anyTrip && !coreRst && !hwResetN == 1'b0
    ##1 (!anyTrip && !coreRst) [*2] |-> ##[1:SD_WAIT_MAX] speaker_shutdown_event)
    else $error("no shutdown event after protective shutdown");
  pin_keep_a: assert property (stateReg == rbsp_pkg::ST_SLEEP && !reset
    |=> $stable(pinSelReg))
    else $error("always-on pin setup lost in sleep");

endmodule

// ### shared/rbsp_pkg.sv
/*
  Constants for the reset, boot and speaker protection supervisor.
  Assumes a 16-bit address / 16-bit data control register port.
*/
package rbsp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] SWRESET_ADDR   = 16'h0000;
  localparam logic [15:0] STATUS5_ADDR   = 16'h0D23;
  localparam logic [15:0] SPK_CTRL_ADDR  = 16'h0040;
  localparam logic [15:0] SPK_STAT_ADDR  = 16'h0041;
  localparam logic [15:0] PIN_SEL_ADDR   = 16'h0042;
  localparam int          BOOT_FLAG_BIT  = 8;
  localparam int          STAT_ON_LSB    = 8;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0]  PIN_SEL_RESET  = 3'h0;
  localparam int          BOOT_CYCLES    = 64;
  localparam int          SHUTDOWN_CYCLES = 16;

  // ----------------------------------------------------------------
  // Functions selectable on the fifth general pin
  // ----------------------------------------------------------------
  localparam logic [2:0]  PIN_OFF        = 3'h0;
  localparam logic [2:0]  PIN_WARN       = 3'h1;
  localparam logic [2:0]  PIN_THRESH     = 3'h2;
  localparam logic [2:0]  PIN_SHORT      = 3'h3;
  localparam logic [2:0]  PIN_BOOT       = 3'h4;

  // Supervisor states
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_BOOT  = 2'b10,
    ST_READY = 2'b11
  } rbsp_state_t;

endpackage
